// ---- pkg/sysctl_pkg.sv ----
package sysctl_pkg;

    // register byte offsets (block-local map)
    localparam logic [11:0] OFF_ICS    = 12'h004;
    localparam logic [11:0] OFF_VTO    = 12'h008;
    localparam logic [11:0] OFF_AIRC   = 12'h00C;
    localparam logic [11:0] OFF_LPC    = 12'h010;
    localparam logic [11:0] OFF_PRIO   = 12'h014;

    // interrupt_control_state fields
    localparam int ICS_NMI_SET   = 31;
    localparam int ICS_DS_SET    = 28;
    localparam int ICS_DS_CLR    = 27;
    localparam int ICS_TICK_SET  = 26;
    localparam int ICS_TICK_CLR  = 25;
    localparam int ICS_ANY_PEND  = 22;
    localparam int ICS_PEND_LSB  = 12;
    localparam int ICS_PREEMPTED = 11;
    localparam int VEC_W         = 9;

    // vector_table_offset fields
    localparam int VTO_LSB = 7;

    // app_interrupt_reset_control fields
    localparam logic [15:0] AIRC_KEY_WR = 16'h05FA;
    localparam logic [15:0] AIRC_KEY_RD = 16'hFA05;
    localparam int          AIRC_KEY_LSB = 16;
    localparam int          AIRC_ENDIAN  = 15;
    localparam int          AIRC_SPLIT_LSB = 8;
    localparam int          AIRC_RST_REQ = 2;
    localparam logic [2:0]  SPLIT_RESET  = 3'h0;

    // low_power_control fields
    localparam int LPC_WAKE_ANY = 4;
    localparam int LPC_DEEP     = 2;
    localparam int LPC_ON_RET   = 1;

    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    typedef struct packed {
        logic             psel;
        logic             penable;
        logic             pwrite;
        logic [11:0]      paddr;
        logic [31:0]      pwdata;
    } sysctl_apb_req_t;

    typedef struct packed {
        logic [VEC_W-1:0] active_vec;
        logic             preempted_active;
        logic [VEC_W-1:0] pending_vec;
        logic             any_irq_pending;
        logic [7:0]       active_prio;
        logic [7:0]       pending_prio;
    } sysctl_exc_state_t;

    typedef struct packed {
        logic irq_enabled_pend;
        logic irq_disabled_pend;
        logic event_in;
        logic send_event;
        logic wait_for_event;
        logic handler_return;
    } sysctl_power_in_t;

endpackage

// ---- hdl/sysctl_regs.sv ----
`timescale 1ns/1ps
//Contract
// - writing one pends the non-maskable interrupt
// - set and clear bits for deferred, tick
// - report active exception and preempted flag
// - report top pending exception, any-pending flag
// - table offset held in upper field
// - low seven offset bits read zero
// - writes need key; key readback reads FA05
// - read-only endianness bit, fixed
// - three-bit priority split field
// - narrow priorities padded with zero bits
// - preemption compares group priority only
// - keyed write pulses system reset request
// - wake-on-pending selects which interrupts wake
// - pending event wakes or is latched
// - send-event and external event also wake
// - deep-sleep select chooses sleep mode
// - sleep on handler return when set
module sysctl_regs #(
    parameter logic       BIG_ENDIAN  = 1'b0,
    parameter logic [2:0] MIN_SPLIT   = 3'h0,
    parameter int         PRIO_BITS   = 8
) (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [11:0]                 paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire sysctl_pkg::sysctl_exc_state_t exc_state,
    input  wire sysctl_pkg::sysctl_power_in_t  pwr_in,
    input  wire logic                        nmi_taken,
    input  wire logic                        ds_taken,
    input  wire logic                        tick_taken,
    output logic                             nmi_pending,
    output logic                             ds_pending,
    output logic                             tick_pending,
    output logic      [31:0]                 table_base,
    output logic      [2:0]                  split_point,
    output logic                             preempt,
    output logic                             sys_reset_req,
    output logic                             wake,
    output logic                             sleep_now,
    output logic                             deep_sleep
);
    import sysctl_pkg::*;

    logic        wr_acc;
    logic        rd_acc;
    logic        hit;
    logic        key_ok;
    logic [31:0] rd_nxt;
    logic [31:7] vto_r;
    logic [2:0]  split_r;
    logic        wake_any_r;
    logic        deep_r;
    logic        on_ret_r;
    logic        event_latch_r;
    logic        wake_src;
    logic [7:0]  grp_mask;
    logic [7:0]  prio_mask;
    logic [7:0]  act_p;
    logic [7:0]  pend_p;

    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && !penable && !pwrite;
    assign key_ok = pwdata[31:16] == AIRC_KEY_WR;

    assign hit = (paddr == OFF_ICS) || (paddr == OFF_VTO) || (paddr == OFF_AIRC)
              || (paddr == OFF_LPC);

    // one-cycle access phase; unmapped addresses answer with an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !hit;
        end
    end

    // set wins over the core's acceptance; software clear wins over hold
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nmi_pending  <= 1'b0;
            ds_pending   <= 1'b0;
            tick_pending <= 1'b0;
        end else begin
            if (wr_acc && paddr == OFF_ICS && pwdata[ICS_NMI_SET])
                nmi_pending <= 1'b1;
            else if (nmi_taken)
                nmi_pending <= 1'b0;
            if (wr_acc && paddr == OFF_ICS && pwdata[ICS_DS_SET])
                ds_pending <= 1'b1;
            else if ((wr_acc && paddr == OFF_ICS && pwdata[ICS_DS_CLR]) || ds_taken)
                ds_pending <= 1'b0;
            if (wr_acc && paddr == OFF_ICS && pwdata[ICS_TICK_SET])
                tick_pending <= 1'b1;
            else if ((wr_acc && paddr == OFF_ICS && pwdata[ICS_TICK_CLR]) || tick_taken)
                tick_pending <= 1'b0;
        end
    end

    // bits below VTO_LSB are not stored at all
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vto_r <= '0;
        end else if (wr_acc && paddr == OFF_VTO) begin
            vto_r <= pwdata[31:VTO_LSB];
        end
    end

    assign table_base = {vto_r, 7'h00};

    // optional low split values are raised to the implemented minimum
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            split_r       <= SPLIT_RESET;
            sys_reset_req <= 1'b0;
        end else begin
            sys_reset_req <= wr_acc && paddr == OFF_AIRC && key_ok
                             && pwdata[AIRC_RST_REQ];
            if (wr_acc && paddr == OFF_AIRC && key_ok) begin
                if (pwdata[10:8] < MIN_SPLIT)
                    split_r <= MIN_SPLIT;
                else
                    split_r <= pwdata[10:8];
            end
        end
    end

    assign split_point = split_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_any_r <= 1'b0;
            deep_r     <= 1'b0;
            on_ret_r   <= 1'b0;
        end else if (wr_acc && paddr == OFF_LPC) begin
            wake_any_r <= pwdata[LPC_WAKE_ANY];
            deep_r     <= pwdata[LPC_DEEP];
            on_ret_r   <= pwdata[LPC_ON_RET];
        end
    end

    // group mask keeps bits [7:n+1]; n=7 leaves nothing
    always_comb begin
        grp_mask  = 8'hFF << (split_r + 3'h1);
        if (split_r == 3'h7)
            grp_mask = 8'h00;
        prio_mask = 8'hFF << (8 - PRIO_BITS);
        act_p     = exc_state.active_prio & prio_mask;
        pend_p    = exc_state.pending_prio & prio_mask;
    end

    // lower value is higher priority; subpriority never preempts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            preempt <= 1'b0;
        end else begin
            preempt <= (exc_state.pending_vec != '0)
                       && ((pend_p & grp_mask) < (act_p & grp_mask)
                           || exc_state.active_vec == '0);
        end
    end

    assign wake_src = pwr_in.irq_enabled_pend
                   || (wake_any_r && pwr_in.irq_disabled_pend)
                   || pwr_in.event_in || pwr_in.send_event;

    // an event seen while not waiting is held for the next wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_latch_r <= 1'b0;
            wake          <= 1'b0;
        end else begin
            wake <= pwr_in.wait_for_event && (wake_src || event_latch_r);
            if (wake_src && !pwr_in.wait_for_event)
                event_latch_r <= 1'b1;
            else if (pwr_in.wait_for_event)
                event_latch_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_now  <= 1'b0;
            deep_sleep <= 1'b0;
        end else begin
            sleep_now  <= pwr_in.handler_return && on_ret_r;
            deep_sleep <= deep_r;
        end
    end

    // read mux; write-only bits and reserved bits return zero
    always_comb begin
        rd_nxt = ZERO_WORD;
        if (paddr == OFF_ICS) begin
            rd_nxt[ICS_NMI_SET]   = nmi_pending;
            rd_nxt[ICS_DS_SET]    = ds_pending;
            rd_nxt[ICS_TICK_SET]  = tick_pending;
            rd_nxt[ICS_ANY_PEND]  = exc_state.any_irq_pending;
            rd_nxt[ICS_PEND_LSB +: VEC_W] = exc_state.pending_vec;
            rd_nxt[ICS_PREEMPTED] = exc_state.preempted_active;
            rd_nxt[VEC_W-1:0]     = exc_state.active_vec;
        end else if (paddr == OFF_VTO) begin
            rd_nxt[31:VTO_LSB] = vto_r;
        end else if (paddr == OFF_AIRC) begin
            rd_nxt[31:AIRC_KEY_LSB] = AIRC_KEY_RD;
            rd_nxt[AIRC_ENDIAN]     = BIG_ENDIAN;
            rd_nxt[10:AIRC_SPLIT_LSB] = split_r;
        end else if (paddr == OFF_LPC) begin
            rd_nxt[LPC_WAKE_ANY] = wake_any_r;
            rd_nxt[LPC_DEEP]     = deep_r;
            rd_nxt[LPC_ON_RET]   = on_ret_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= ZERO_WORD;
        else if (rd_acc)
            prdata <= rd_nxt;
    end

endmodule // sysctl_regs

// ---- bench/sysctl_regs_checker.sv ----
`timescale 1ns/1ps
module sysctl_regs_checker #(
    parameter logic BIG_ENDIAN = 1'b0
) (
    input wire logic                        pclk,
    input wire logic                        presetn,
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pwrite,
    input wire logic [11:0]                 paddr,
    input wire logic [31:0]                 pwdata,
    input wire logic [31:0]                 prdata,
    input wire logic                        pready,
    input wire logic                        pslverr,
    input wire sysctl_pkg::sysctl_power_in_t pwr_in,
    input wire logic                        nmi_pending,
    input wire logic                        ds_pending,
    input wire logic                        tick_pending,
    input wire logic [31:0]                 table_base,
    input wire logic [2:0]                  split_point,
    input wire logic                        sys_reset_req,
    input wire logic                        wake,
    input wire logic                        sleep_now,
    input wire logic                        deep_sleep
);
    import sysctl_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence wr_at(logic [11:0] a);
        psel && penable && pwrite && paddr == a;
    endsequence
    sequence keyed;
        wr_at(OFF_AIRC) ##0 pwdata[31:16] == AIRC_KEY_WR;
    endsequence
    AST_NMI_SET: assert property (wr_at(OFF_ICS) ##0 pwdata[31] |=> nmi_pending)
        else $error("nmi not pending");
    AST_DS_CLR: assert property (wr_at(OFF_ICS) ##0 pwdata[27] && !pwdata[28] |=> !ds_pending)
        else $error("deferred not cleared");
    AST_TICK_SET: assert property (wr_at(OFF_ICS) ##0 pwdata[26] |=> tick_pending)
        else $error("tick not pending");
    AST_BAD_KEY: assert property (wr_at(OFF_AIRC) ##0 pwdata[31:16] != AIRC_KEY_WR
        |=> $stable(split_point) && !sys_reset_req) else $error("unkeyed write acted");
    AST_RST_PULSE: assert property (keyed ##0 pwdata[2] |=> sys_reset_req ##1 !sys_reset_req)
        else $error("reset request not one pulse");
    AST_SPLIT: assert property (keyed |=> split_point == $past(pwdata[10:8]))
        else $error("split point wrong");
    AST_KEY_READ: assert property (psel && penable && !pwrite && pready && paddr == OFF_AIRC
        |-> prdata[31:16] == AIRC_KEY_RD && prdata[15] == BIG_ENDIAN && prdata[2:0] == 3'h0)
        else $error("key readback wrong");
    AST_TABLE: assert property (wr_at(OFF_VTO) |=> table_base == {$past(pwdata[31:7]), 7'h00})
        else $error("table base wrong");
    AST_DEEP: assert property (wr_at(OFF_LPC) |=> ##1 deep_sleep == $past(pwdata[2], 2))
        else $error("deep select wrong");
    AST_SLEEP: assert property (sleep_now |-> $past(pwr_in.handler_return))
        else $error("sleep without return");
    AST_WAKE: assert property (pwr_in.wait_for_event && pwr_in.send_event |-> ##[0:2] wake)
        else $error("no wake on send event");
endmodule // sysctl_regs_checker

bind sysctl_regs sysctl_regs_checker #(.BIG_ENDIAN(BIG_ENDIAN)) sysctl_regs_checker_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .pwr_in, .nmi_pending, .ds_pending, .tick_pending, .table_base, .split_point,
    .sys_reset_req, .wake, .sleep_now, .deep_sleep);

// ---- bench/sysctl_regs_tb.sv ----
`timescale 1ns/1ps
module sysctl_regs_tb;
    import sysctl_pkg::*;
    logic              pclk = 1'b0;
    logic              presetn = 1'b0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [11:0]       paddr = 12'h000;
    logic [31:0]       pwdata = 32'h0000_0000;
    sysctl_exc_state_t exc_state = '0;
    sysctl_power_in_t  pwr_in = '0;
    logic [2:0]        tk = 3'h0;
    logic [31:0]       prdata, table_base, d, rd;
    logic [11:0]       a;
    logic [2:0]        split_point;
    logic              pready, pslverr, nmi_pending, ds_pending, tick_pending;
    logic              sys_reset_req, wake, sleep_now, deep_sleep, w, err, rst, preempt;
    logic [7:0]        gm;
    logic [11:0]       addrs [5] = '{OFF_ICS, OFF_VTO, OFF_AIRC, OFF_LPC, OFF_PRIO};
    int                failures = 0;
    int                num_checks = 0;
    int                cyc = 0;
    int                m_ics, m_vto, m_spl, m_lpc;

    sysctl_regs sysctl_regs_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .exc_state, .pwr_in, .nmi_taken(tk[2]), .ds_taken(tk[1]),
        .tick_taken(tk[0]), .nmi_pending, .ds_pending, .tick_pending, .table_base,
        .split_point, .preempt, .sys_reset_req, .wake, .sleep_now, .deep_sleep);

    initial forever #5 pclk = ~pclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        if (failures == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // holds the request until pready is seen; a hung slave ends in the cycle ceiling
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [31:0] exp_rd(input logic [11:0] ad);
        case (ad)
            OFF_ICS: return m_ics | {9'h0, exc_state.any_irq_pending, 1'b0, exc_state.pending_vec,
                exc_state.preempted_active, 2'b0, exc_state.active_vec};
            OFF_VTO: return m_vto;
            OFF_AIRC: return {AIRC_KEY_RD, 1'b0, 4'h0, m_spl[2:0], 8'h00};
            OFF_LPC: return m_lpc;
            default: return 32'h0000_0000;
        endcase
    endfunction

    task automatic do_reset;
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        chk({nmi_pending, ds_pending, tick_pending, sys_reset_req, deep_sleep, split_point}, 0);
        chk(table_base, 32'h0000_0000);
        presetn <= 1'b1;
        m_ics = 0;
        m_vto = 0;
        m_spl = 0;
        m_lpc = 0;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc > 20000) begin
            failures++;
            report_and_stop;
        end
    end

    initial begin
        void'($urandom(62));
        repeat (2) begin
            do_reset;
            for (int i = 0; i < 400; i++) begin
                @(posedge pclk);
                tk <= 3'($urandom);
                exc_state <= 36'({$urandom, $urandom});
                pwr_in <= 6'($urandom);
                @(posedge pclk);
                tk <= 3'h0;
                m_ics = m_ics & ~{tk[2], 2'b0, tk[1], 1'b0, tk[0], 26'h0};
                a = addrs[$urandom % 5];
                w = 1'($urandom);
                d = $urandom;
                if (a == OFF_AIRC && ($urandom % 2)) d[31:16] = AIRC_KEY_WR;
                if (a == OFF_AIRC) d[1:0] = 2'b00;
                if (a == OFF_VTO) d[6:0] = 7'h00;
                if (d[28]) d[27] = 1'b0;
                if (d[26]) d[25] = 1'b0;
                apb(w, a, d);
                #1;
                if (!w) chk(rd, exp_rd(a));
                chk({31'h0, err}, {31'h0, a == OFF_PRIO});
                rst = w && a == OFF_AIRC && d[31:16] == AIRC_KEY_WR;
                if (w && a == OFF_ICS) m_ics = (m_ics | (d & 32'h9400_0000)) & ~((d & 32'h0A00_0000) << 1);
                if (w && a == OFF_VTO) m_vto = d & 32'hFFFF_FF80;
                if (rst) m_spl = d[10:8];
                if (w && a == OFF_LPC) m_lpc = d & 32'h0000_0016;
                chk({nmi_pending, 2'b0, ds_pending, 1'b0, tick_pending, 26'h0}, m_ics);
                chk(table_base, m_vto);
                chk({sys_reset_req, split_point}, {rst && d[2], m_spl[2:0]});
                // deep select and preemption are registered one cycle behind the control bits
                @(posedge pclk);
                #1;
                chk({31'h0, deep_sleep}, {31'h0, m_lpc[2]});
                gm = (m_spl == 7) ? 8'h00 : 8'(8'hFF << (m_spl + 1));
                chk({31'h0, preempt}, {31'h0, (exc_state.pending_vec != 0)
                    && ((exc_state.pending_prio & gm) < (exc_state.active_prio & gm)
                        || exc_state.active_vec == 0)});
            end
        end
        report_and_stop;
    end
endmodule // sysctl_regs_tb
